// ==== core/sfc_pkg.sv ====
// package: register map, field positions, reset values and types for serial frame control
package sfc_pkg;
  localparam logic [1:0] SFC_ADDR_CTRL_ONE  = 2'h0; // serial_control_one
  localparam logic [1:0] SFC_ADDR_CTRL_TWO  = 2'h1; // serial_control_two
  localparam logic [1:0] SFC_ADDR_STATUS    = 2'h2; // flags and transmit state, read only
  localparam logic [1:0] SFC_ADDR_TX_DATA   = 2'h3; // transmit buffer, write only
  // serial_control_one fields
  localparam int SFC_LOOP_BIT   = 7;
  localparam int SFC_FREEZE_BIT = 6;
  localparam int SFC_RXSRC_BIT  = 5;
  localparam int SFC_NINE_BIT   = 4;
  localparam int SFC_WAKE_BIT   = 3;
  localparam int SFC_IDLEO_BIT  = 2;
  localparam int SFC_PEN_BIT    = 1;
  localparam int SFC_PODD_BIT   = 0;
  // serial_control_two fields
  localparam int SFC_TIE_BIT    = 7;
  localparam int SFC_TX_DONE_IRQ_EN_BIT   = 6;
  localparam int SFC_RIE_BIT    = 5;
  localparam int SFC_IDLE_IRQ_EN_BIT   = 4;
  localparam int SFC_TE_BIT     = 3;
  localparam logic [7:0] SFC_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] SFC_CTRL_TWO_RST = 8'h00;
  // bit time in system clocks (fixed divider standing in for the baud generator)
  localparam logic [7:0] SFC_BIT_CYCLES   = 8'h10;
  localparam logic [3:0] SFC_IDLE_BITS    = 4'h0;
  typedef enum logic [1:0] {
    SFC_TX_IDLE  = 2'b00,
    SFC_TX_FRAME = 2'b01,
    SFC_TX_PREAM = 2'b10
  } sfc_tx_state_t;
  typedef struct packed {
    logic tx_buffer_empty;
    logic tx_done_flag;
    logic rx_full_flag;
    logic idle_flag;
  } sfc_flags_t;
  typedef struct packed {
    logic tx_out;
    logic tx_oe_n;
    logic tx_owned;
    logic rx_in;
  } sfc_pins_t;
endpackage : sfc_pkg

// ==== core/sfc_core.sv ====
// serial frame control: control registers, transmitter, pin routing and interrupt request
// Summary of operation
// - loop select 0 gives separate pins; 1 routes transmitter to receiver, internally or through the transmit pin
// - receiver source select has effect only when loop select is 1
// - loop 1, source 0: internal loopback, receive pin unused
// - loop 1, source 1: transmitter drives the transmit pin, which feeds the receiver
// - freeze bit 0 keeps clocks in wait; 1 stops them while waiting
// - eight or nine data bits, lsb first, start and stop, both directions
// - wakeup bit selects idle-line (0) or address-mark (1) standby exit
// - idle count origin: after start bit (0) or after stop bit (1)
// - parity enable generates and checks parity in the top data bit
// - parity type 0 even ones count, 1 odd
// - transmit empty enable requests interrupt while buffer empty flag set
// - done enable requests interrupt while transmission complete flag set
// - receive enable requests interrupt while receive full flag set
// - idle enable requests interrupt while idle flag set
// - transmitter starts frames only when enabled and then owns the transmit pin
// - in single wire the direction bit sets traffic direction on the pin
// - enable written 0 then 1 mid-transmission queues an idle character
// - after disable the pin stays owned until pending traffic finishes
// - buffer empty flag set at reset and on each buffer-to-shifter move
// - complete flag set at reset and when empty with nothing sending
`timescale 1ns/10ps
`default_nettype none
module sfc_core
  import sfc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_tx_pin,
  input  wire logic       i_rx_pin,
  input  wire logic       i_one_wire_direction,
  input  wire logic       i_cpu_wait,
  input  wire logic       i_rx_full_flag,
  input  wire logic       i_idle_flag,
  output logic            o_tx_pin,
  output logic            o_tx_pin_oe_n,
  output logic            o_rx_pin_used,
  output logic            o_rx_data_in,
  output logic            o_clk_run,
  output logic            o_nine_bit,
  output logic            o_wake_addr_mark,
  output logic            o_idle_after_stop,
  output logic            o_parity_enable,
  output logic            o_parity_odd_select,
  output logic            o_irq
);

  logic [7:0]    serial_control_one;
  logic [7:0]    serial_control_two;
  logic [8:0]    tx_buf;
  sfc_flags_t    flags;
  sfc_tx_state_t tx_state;
  sfc_tx_state_t next_tx_state;
  logic [10:0]   shifter;
  logic [3:0]    bits_left;
  logic [7:0]    bit_timer;
  logic          idle_queued;
  logic          tx_line;
  logic          rx_pin_s1, rx_pin_s2, tx_pin_s1, tx_pin_s2;
  logic          status_read_tc;
  logic          tx_empty_q;  // transmit buffer empty flag register
  logic          tx_done_q;   // transmission complete flag register
  logic          tx_quiet;    // nothing sending, queued or arriving after this cycle
  logic          te_rise;
  logic          load_frame;
  logic          bit_end;
  logic          pins_owned;
  logic          internal_loop, single_wire;

  // parity bit value for the top data bit position
  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    parity_of = (^d) ^ odd;
  endfunction

  // control registers, plain read/write at any time
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      serial_control_one <= SFC_CTRL_ONE_RST;
      serial_control_two <= SFC_CTRL_TWO_RST;
    end else if (i_wr) begin
      if (i_addr == SFC_ADDR_CTRL_ONE) serial_control_one <= i_wdata;
      if (i_addr == SFC_ADDR_CTRL_TWO) serial_control_two <= i_wdata;
    end
  end

  assign te_rise = i_wr && (i_addr == SFC_ADDR_CTRL_TWO) && i_wdata[SFC_TE_BIT]
                   && !serial_control_two[SFC_TE_BIT];

  // read data, one cycle after the read strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        SFC_ADDR_CTRL_ONE: o_rdata <= serial_control_one;
        SFC_ADDR_CTRL_TWO: o_rdata <= serial_control_two;
        SFC_ADDR_STATUS:   o_rdata <= {flags, 2'h0, tx_state};
        default:           o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // status read arms the complete-flag clear sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) status_read_tc <= 1'b0;
    else if (i_rd && i_addr == SFC_ADDR_STATUS) status_read_tc <= flags.tx_done_flag;
    // the arming read is used up by the step that clears the flag
    else if ((i_wr && i_addr == SFC_ADDR_TX_DATA) || te_rise) status_read_tc <= 1'b0;
  end

  // two-flop synchronisers for pin inputs
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_pin_s1 <= 1'b1;
      rx_pin_s2 <= 1'b1;
      tx_pin_s1 <= 1'b1;
      tx_pin_s2 <= 1'b1;
    end else begin
      rx_pin_s1 <= i_rx_pin;
      rx_pin_s2 <= rx_pin_s1;
      tx_pin_s1 <= i_tx_pin;
      tx_pin_s2 <= tx_pin_s1;
    end
  end

  // bit timer paces the shifter
  assign bit_end = (bit_timer == SFC_BIT_CYCLES - 8'h01);
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || tx_state == SFC_TX_IDLE) bit_timer <= 8'h00;
    else if (bit_end) bit_timer <= 8'h00;
    else bit_timer <= bit_timer + 8'h01;
  end

  // start a frame when enabled and data waits, and no queued idle is due
  assign load_frame = (tx_state == SFC_TX_IDLE) && serial_control_two[SFC_TE_BIT]
                      && !flags.tx_buffer_empty && !idle_queued;

  // transmitter state machine
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      SFC_TX_IDLE: begin
        if (idle_queued) next_tx_state = SFC_TX_PREAM;
        else if (load_frame) next_tx_state = SFC_TX_FRAME;
      end
      SFC_TX_FRAME, SFC_TX_PREAM: begin
        if (bit_end && bits_left == SFC_IDLE_BITS) next_tx_state = SFC_TX_IDLE;
      end
      default: next_tx_state = SFC_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) tx_state <= SFC_TX_IDLE;
    else tx_state <= next_tx_state;
  end

  // queued idle: enable re-raised, whether traffic is active or not
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) idle_queued <= 1'b0;
    else if (te_rise) idle_queued <= 1'b1;
    else if (tx_state == SFC_TX_IDLE) idle_queued <= 1'b0;
  end

  // shifter: start, data lsb first, optional ninth bit, stop
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      shifter   <= 11'h7ff;
      bits_left <= 4'h0;
    end else if (tx_state == SFC_TX_IDLE && idle_queued) begin
      shifter   <= 11'h7ff;
      bits_left <= serial_control_one[SFC_NINE_BIT] ? 4'ha : 4'h9;
    end else if (load_frame) begin
      if (serial_control_one[SFC_NINE_BIT]) begin
        shifter   <= {1'b1,
                      serial_control_one[SFC_PEN_BIT] ?
                        parity_of(tx_buf[7:0], serial_control_one[SFC_PODD_BIT]) :
                        tx_buf[8],
                      tx_buf[7:0], 1'b0};
        bits_left <= 4'ha;
      end else begin
        shifter   <= {2'b11,
                      serial_control_one[SFC_PEN_BIT] ?
                        parity_of({1'b0, tx_buf[6:0]}, serial_control_one[SFC_PODD_BIT]) :
                        tx_buf[7],
                      tx_buf[6:0], 1'b0};
        bits_left <= 4'h9;
      end
    end else if (tx_state != SFC_TX_IDLE && bit_end) begin
      shifter   <= {1'b1, shifter[10:1]};
      bits_left <= bits_left - 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) tx_line <= 1'b1;
    else tx_line <= (tx_state == SFC_TX_IDLE) ? 1'b1 : shifter[0];
  end

  // transmitter quiet: no frame, queued idle or new data pending
  assign tx_quiet = next_tx_state == SFC_TX_IDLE && flags.tx_buffer_empty && !load_frame
                    && !idle_queued && !te_rise && !(i_wr && i_addr == SFC_ADDR_TX_DATA);

  // transmit buffer and flags; hardware set wins over software clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_buf     <= 9'h000;
      tx_empty_q <= 1'b1;
      tx_done_q  <= 1'b1;
    end else begin
      if (i_wr && i_addr == SFC_ADDR_TX_DATA) begin
        tx_buf     <= {1'b0, i_wdata};
        tx_empty_q <= 1'b0;
      end
      if (load_frame) tx_empty_q <= 1'b1;
      if (status_read_tc && ((i_wr && i_addr == SFC_ADDR_TX_DATA) || te_rise))
        tx_done_q <= 1'b0;
      if (tx_quiet) tx_done_q <= 1'b1;
    end
  end

  // flag bundle, one driver for all four fields
  always_comb begin
    flags.tx_buffer_empty = tx_empty_q;
    flags.tx_done_flag    = tx_done_q;
    flags.rx_full_flag    = i_rx_full_flag;
    flags.idle_flag       = i_idle_flag;
  end

  // pin routing
  assign internal_loop = serial_control_one[SFC_LOOP_BIT] && !serial_control_one[SFC_RXSRC_BIT];
  assign single_wire   = serial_control_one[SFC_LOOP_BIT] && serial_control_one[SFC_RXSRC_BIT];
  assign pins_owned    = serial_control_two[SFC_TE_BIT] || tx_state != SFC_TX_IDLE
                         || idle_queued;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_tx_pin      <= 1'b1;
      o_tx_pin_oe_n <= 1'b1;
      o_rx_pin_used <= 1'b1;
      o_rx_data_in  <= 1'b1;
    end else begin
      o_tx_pin      <= tx_line;
      // single wire: direction bit chooses drive or listen
      o_tx_pin_oe_n <= !(pins_owned && (!single_wire || i_one_wire_direction));
      o_rx_pin_used <= !serial_control_one[SFC_LOOP_BIT];
      if (!serial_control_one[SFC_LOOP_BIT]) o_rx_data_in <= rx_pin_s2;
      else if (internal_loop) o_rx_data_in <= tx_line;
      else o_rx_data_in <= tx_pin_s2;
    end
  end

  // mode outputs for the receiver and clocking
  assign o_clk_run           = !(i_cpu_wait && serial_control_one[SFC_FREEZE_BIT]);
  assign o_nine_bit          = serial_control_one[SFC_NINE_BIT];
  assign o_wake_addr_mark    = serial_control_one[SFC_WAKE_BIT];
  assign o_idle_after_stop   = serial_control_one[SFC_IDLEO_BIT];
  assign o_parity_enable     = serial_control_one[SFC_PEN_BIT];
  assign o_parity_odd_select = serial_control_one[SFC_PODD_BIT];

  // interrupt request
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) o_irq <= 1'b0;
    else o_irq <= (flags.tx_buffer_empty && serial_control_two[SFC_TIE_BIT])
               || (flags.tx_done_flag && serial_control_two[SFC_TX_DONE_IRQ_EN_BIT])
               || (flags.rx_full_flag && serial_control_two[SFC_RIE_BIT])
               || (flags.idle_flag && serial_control_two[SFC_IDLE_IRQ_EN_BIT]);
  end

  sequence s_loop_on;
    serial_control_one[SFC_LOOP_BIT] && !serial_control_one[SFC_RXSRC_BIT];
  endsequence

  a_irq_from_empty: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    flags.tx_buffer_empty && serial_control_two[SFC_TIE_BIT] |=> o_irq)
    else $error("empty flag with enable gave no irq");
  a_irq_from_done: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    flags.tx_done_flag && serial_control_two[SFC_TX_DONE_IRQ_EN_BIT] |=> o_irq)
    else $error("done flag with enable gave no irq");
  a_irq_from_rx: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_rx_full_flag && serial_control_two[SFC_RIE_BIT] |=> o_irq)
    else $error("rx full with enable gave no irq");
  a_irq_from_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_idle_flag && serial_control_two[SFC_IDLE_IRQ_EN_BIT] |=> o_irq)
    else $error("idle with enable gave no irq");
  a_irq_quiet: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    serial_control_two[7:4] == 4'h0 |=> !o_irq)
    else $error("irq with all enables clear");
  a_loop_rx_unused: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    s_loop_on |=> !o_rx_pin_used && o_rx_data_in == $past(tx_line))
    else $error("loopback did not route transmitter");
  a_pin_held_busy: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    tx_state != SFC_TX_IDLE && !single_wire |=> !o_tx_pin_oe_n)
    else $error("pin released while sending");
  a_empty_on_load: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    load_frame |=> flags.tx_buffer_empty ##0 tx_state == SFC_TX_FRAME)
    else $error("load did not set empty flag");
  a_idle_queued: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    te_rise && tx_state == SFC_TX_FRAME |=> idle_queued)
    else $error("idle not queued");
  a_freeze_wait: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_cpu_wait && !serial_control_one[SFC_FREEZE_BIT] |-> o_clk_run)
    else $error("clock stopped in wait without freeze");
  a_freeze_stop: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_cpu_wait && serial_control_one[SFC_FREEZE_BIT] |-> !o_clk_run)
    else $error("clock ran in wait with freeze");

  // pin routing checks
  a_sep_pins: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !serial_control_one[SFC_LOOP_BIT] |=> o_rx_pin_used && o_rx_data_in == $past(rx_pin_s2))
    else $error("separate pins not used");
  a_rxsrc_ignored: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !serial_control_one[SFC_LOOP_BIT] && serial_control_one[SFC_RXSRC_BIT]
    |=> o_rx_data_in == $past(rx_pin_s2))
    else $error("source select acted without loop");
  a_one_wire_rx: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    single_wire |=> !o_rx_pin_used && o_rx_data_in == $past(tx_pin_s2))
    else $error("single wire did not feed receiver");
  a_one_wire_dir: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    single_wire && pins_owned |=> o_tx_pin_oe_n == !$past(i_one_wire_direction))
    else $error("single wire direction ignored");
  a_tx_on_drive: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    serial_control_two[SFC_TE_BIT] && !single_wire |=> !o_tx_pin_oe_n)
    else $error("enabled transmitter not driving pin");
  a_tx_off_release: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !pins_owned |=> o_tx_pin_oe_n)
    else $error("pin driven while not owned");
  a_pin_held_queue: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    idle_queued && !single_wire |=> !o_tx_pin_oe_n)
    else $error("pin released with idle queued");

  // frame format checks
  a_start_bit: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    load_frame |=> shifter[0] == 1'b0
    && bits_left == ($past(serial_control_one[SFC_NINE_BIT]) ? 4'ha : 4'h9))
    else $error("frame not loaded with start bit");
  a_frame_shift: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    tx_state != SFC_TX_IDLE && bit_end
    |=> bits_left == $past(bits_left) - 4'h1 && shifter[9:0] == $past(shifter[10:1]))
    else $error("shifter not lsb first");
  a_parity_gen: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    load_frame && serial_control_one[SFC_PEN_BIT]
    |=> (^(shifter[9:1] & ($past(serial_control_one[SFC_NINE_BIT]) ? 9'h1ff : 9'h0ff)))
        == $past(serial_control_one[SFC_PODD_BIT]))
    else $error("wrong parity in frame");
  a_raw_top_bit: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    load_frame && !serial_control_one[SFC_PEN_BIT] && serial_control_one[SFC_NINE_BIT]
    |=> shifter[9] == $past(tx_buf[8]))
    else $error("ninth bit not from buffer");
  a_line_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    tx_state == SFC_TX_IDLE |=> tx_line)
    else $error("line not high while idle");

  // queued idle: the last bit of a frame hands over to the preamble
  sequence s_frame_last;
    tx_state == SFC_TX_FRAME && bit_end && bits_left == SFC_IDLE_BITS;
  endsequence

  a_queue_then_pream: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    s_frame_last ##0 idle_queued |=> ##1 tx_state == SFC_TX_PREAM)
    else $error("queued idle not sent");
  a_pream_ones: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    tx_state == SFC_TX_PREAM |=> tx_line)
    else $error("idle character not all ones");

  // complete flag follows transmitter activity
  a_done_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    tx_quiet |=> flags.tx_done_flag)
    else $error("complete flag not set when quiet");
  a_done_busy: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !flags.tx_done_flag && tx_state == SFC_TX_PREAM && !bit_end |=> !flags.tx_done_flag)
    else $error("complete flag set during idle character");

endmodule // sfc_core
`default_nettype wire

// ==== bench/sfc_remote.sv ====
// remote serial device: decodes frames on the shared transmit line, drives the receive line
`timescale 1ns/10ps
`default_nettype none
module sfc_remote (
  input  wire logic       i_sys_clk,
  input  wire logic       i_line,
  input  wire logic       i_nine,
  input  wire logic       i_listen,
  input  wire logic       i_hold_low,
  output logic            o_rx_line,
  output logic            o_got,
  output logic      [9:0] o_word
);
  // receive line idles high, pulled low only on request
  assign o_rx_line = ~i_hold_low;
  // decoder samples mid bit, 16 clocks a bit, lsb first, stop bit kept in the top position
  initial begin
    o_got = 1'b0;
    o_word = 10'h000;
    forever begin
      @(negedge i_line iff i_listen);
      o_word <= 10'h000;
      repeat (8) @(posedge i_sys_clk);
      for (int b = 0; b < (i_nine ? 10 : 9); b++) begin
        repeat (16) @(posedge i_sys_clk);
        if (b == (i_nine ? 9 : 8)) o_word[9] <= i_line;
        else o_word[b] <= i_line;
      end
      o_got <= 1'b1;
      @(posedge i_sys_clk);
      o_got <= 1'b0;
    end
  end
endmodule // sfc_remote
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking testbench for serial frame control
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sfc_pkg::*;
  logic       clk, rst, wr, rd, rd_d, dir, cwait, rxf, idl, tdrv, hold, nine, lsn, got, rxl;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v, w, d;
  logic [9:0] word, e;
  logic [15:0] re;
  logic       txo, oe_n, rx_used, rx_in, clk_run, irq, line;
  logic [4:0] fmt;
  logic [15:0] rq[$];
  logic [9:0]  fq[$];
  int          n_fail = 0;
  int          total_checks = 0;
  logic [7:0] mc[6] = '{8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h10};
  // shared pin: design wins, then the bench, else pull-up
  assign line = !oe_n ? txo : (tdrv ? 1'b0 : 1'b1);
  sfc_core sfc_core_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_pin(line), .i_rx_pin(rxl),
    .i_one_wire_direction(dir), .i_cpu_wait(cwait), .i_rx_full_flag(rxf), .i_idle_flag(idl),
    .o_tx_pin(txo), .o_tx_pin_oe_n(oe_n), .o_rx_pin_used(rx_used), .o_rx_data_in(rx_in),
    .o_clk_run(clk_run), .o_nine_bit(fmt[4]), .o_wake_addr_mark(fmt[3]),
    .o_idle_after_stop(fmt[2]), .o_parity_enable(fmt[1]), .o_parity_odd_select(fmt[0]),
    .o_irq(irq));
  sfc_remote sfc_remote_i (.i_sys_clk(clk), .i_line(line), .i_nine(nine), .i_listen(lsn),
    .i_hold_low(hold), .o_rx_line(rxl), .o_got(got), .o_word(word));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [9:0] g, input logic [9:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] dv);
    @(posedge clk);
    addr <= a; wdata <= dv; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read note holds mask and masked expectation
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] x, input logic [7:0] m);
    @(posedge clk);
    addr <= a; rd <= 1'b1; rq.push_back({m, x & m});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_frames;
    for (int k = 0; k < 1000 && fq.size() != 0; k++) @(posedge clk);
    if (fq.size() != 0) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic send(input logic [7:0] dv, input logic [9:0] x);
    wait_frames();
    fq.push_back(x);
    wr_reg(SFC_ADDR_TX_DATA, dv);
  endtask
  // clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // monitor: take the oldest note as each result appears
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      if (rq.size() == 0) check(10'h3ff, 10'h000);
      else begin
        re = rq.pop_front();
        check(10'(rdata & re[15:8]), 10'(re[7:0]));
      end
    end
    if (got) begin
      if (fq.size() == 0) check(10'h3ff, 10'h000);
      else check(word, fq.pop_front());
    end
  end
  // watchdog against hangs
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    rst = 1'b1; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; dir = 1'b0; cwait = 1'b0;
    rxf = 1'b0; idl = 1'b0; tdrv = 1'b0; hold = 1'b0; nine = 1'b0; lsn = 1'b1;
    void'($urandom(87869));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(SFC_ADDR_CTRL_ONE, 8'h00, 8'hff);
    rd_reg(SFC_ADDR_CTRL_TWO, 8'h00, 8'hff);
    rd_reg(SFC_ADDR_STATUS, 8'hc0, 8'hfc);
    rd_reg(SFC_ADDR_TX_DATA, 8'h00, 8'hff);
    look(2);
    check(10'({oe_n, txo}), 10'h3);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      w = 8'($urandom) & 8'hf7;
      @(posedge clk);
      cwait <= w[0];
      wr_reg(SFC_ADDR_CTRL_ONE, v);
      wr_reg(SFC_ADDR_CTRL_TWO, w);
      wr_reg(SFC_ADDR_STATUS, 8'h00);
      rd_reg(SFC_ADDR_CTRL_ONE, v, 8'hff);
      rd_reg(SFC_ADDR_CTRL_TWO, w, 8'hff);
      look(3);
      check(10'(fmt), 10'(v[4:0]));
      check(10'(rx_used), 10'(!v[7]));
      check(10'(clk_run), 10'(!(w[0] && v[6])));
    end
    $display("test config done");
    wr_reg(SFC_ADDR_CTRL_ONE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int f = 0; f < 2; f++) begin
        @(posedge clk);
        rxf <= f[0]; idl <= f[0];
        wr_reg(SFC_ADDR_CTRL_TWO, 8'h80 >> i);
        look(3);
        check(10'(irq), 10'(i < 2 || f == 1));
      end
    end
    wr_reg(SFC_ADDR_CTRL_TWO, 8'h00);
    look(3);
    check(10'(irq), 10'h0);
    $display("test interrupt done");
    @(posedge clk);
    lsn <= 1'b0; hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tdrv <= (i == 3);
      hold <= (i != 3);
      wr_reg(SFC_ADDR_CTRL_ONE, 8'(i[1] * 8'h80 + i[0] * 8'h20));
      look(6);
      check(10'(rx_in), 10'(i == 2));
    end
    @(posedge clk);
    tdrv <= 1'b0; hold <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      dir <= j[0];
      wr_reg(SFC_ADDR_CTRL_TWO, 8'h08);
      look(4);
      check(10'(oe_n), 10'(j == 0));
      wr_reg(SFC_ADDR_CTRL_TWO, 8'h00);
      look(200);
    end
    @(posedge clk);
    lsn <= 1'b1; dir <= 1'b0;
    $display("test routing done");
    for (int m = 0; m < 6; m++) begin
      @(posedge clk);
      nine <= mc[m][4];
      wr_reg(SFC_ADDR_CTRL_ONE, mc[m]);
      wr_reg(SFC_ADDR_CTRL_TWO, 8'h08);
      for (int k = 0; k < 2; k++) begin
        d = 8'($urandom);
        e[0] = mc[m][0] ^ (mc[m][4] ? ^d : ^d[6:0]);
        if (!mc[m][1]) e = {2'b10, d};
        else if (mc[m][4]) e = {1'b1, e[0], d};
        else e = {2'b10, e[0], d[6:0]};
        send(d, e);
      end
      wait_frames();
      wr_reg(SFC_ADDR_CTRL_TWO, 8'h00);
      look(40);
    end
    $display("test frames done");
    @(posedge clk);
    nine <= 1'b0;
    wr_reg(SFC_ADDR_CTRL_ONE, 8'h00);
    wr_reg(SFC_ADDR_CTRL_TWO, 8'h08);
    look(200);
    send(8'h5a, 10'h25a);
    wr_reg(SFC_ADDR_CTRL_TWO, 8'h00);
    look(1);
    check(10'(oe_n), 10'h0);
    wait_frames();
    look(30);
    check(10'({oe_n, txo}), 10'h3);
    wr_reg(SFC_ADDR_CTRL_TWO, 8'h08);
    look(200);
    rd_reg(SFC_ADDR_STATUS, 8'hc0, 8'hc0);
    send(8'ha3, 10'h2a3);
    wr_reg(SFC_ADDR_CTRL_TWO, 8'h00);
    wr_reg(SFC_ADDR_CTRL_TWO, 8'h08);
    wait_frames();
    look(20);
    rd_reg(SFC_ADDR_STATUS, 8'h00, 8'h40);
    look(200);
    rd_reg(SFC_ADDR_STATUS, 8'h40, 8'h40);
    look(3);
    $display("test disable and idle done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
